// *** asram_pkg.sv ***
// asram_pkg: constants for the host controller of a 128K x 8 asynchronous static memory.
// assumes a 40 MHz system clock; timings are those of the slowest speed grade.
`default_nettype none
package asram_pkg;
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CLK_PS      = 25000;
  // timing in picoseconds
  localparam int unsigned T_RC_PS     = 45000;
  localparam int unsigned T_WP_PS     = 25000;
  localparam int unsigned T_WC_PS     = 45000;
  localparam int unsigned T_HZ_PS     = 18000;
  localparam int unsigned RD_CYC      = (T_RC_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WP_CYC      = (T_WP_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned WC_CYC      = (T_WC_PS + CLK_PS - 1) / CLK_PS;
  localparam int unsigned HZ_CYC      = (T_HZ_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [3:0]  CNT_ZERO    = 4'h0;
  // software register map
  localparam logic [3:0]  REG_ADDR    = 4'h0;
  localparam logic [3:0]  REG_WDATA   = 4'h4;
  localparam logic [3:0]  REG_CMD     = 4'h8;
  localparam logic [3:0]  REG_STATUS  = 4'hC;
  localparam int unsigned CMD_RD_BIT  = 0;
  localparam int unsigned CMD_WR_BIT  = 1;
  localparam logic [31:0] RESET_WORD  = 32'h00000000;
  typedef enum logic [2:0] {
    ASRAM_IDLE, ASRAM_READ, ASRAM_WRITE, ASRAM_TURN
  } asram_state_e;
endpackage
`default_nettype wire

// *** asram_sync.sv ***
// asram_sync: two-flop synchroniser for the returning data lines.
// assumes the input is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module asram_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // asram_sync
`default_nettype wire

// *** asram_host.sv ***
// asram_host: host controller driving a 128K x 8 asynchronous memory over its pins.
// assumes a software port on clk and a memory without clock or reset.
//
// How it works
// - a write stores the data lines while write strobe and low select are low, high select high.
// - the host holds the write strobe high for the whole of any read.
// - writes start and end on the strobe; data is taken only while select and strobe overlap.
// - the host makes the address valid no later than the last select becomes active.
`timescale 1ns/100ps
`default_nettype none
module asram_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [31:0] sw_rdata,
  output logic      [16:0] word_address_lines,
  output logic             select_low_active_n,
  output logic             select_high_active,
  output logic             write_strobe_n,
  output logic             output_enable_n,
  input  wire logic [7:0]  shared_data_lines_in,
  output logic      [7:0]  shared_data_lines_out,
  output logic             shared_data_lines_oe_n
);
  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  asram_pkg::asram_state_e state_q;
  logic [16:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic [3:0]  cnt_q;
  logic        busy_q;
  logic        done_q;
  logic        sel_q;
  logic [7:0]  din_sync;
  logic        start_rd;
  logic        start_wr;

  asram_sync #(.W(asram_pkg::DATA_W)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (shared_data_lines_in),
    .dout (din_sync)
  );

  function automatic logic [3:0] cyc4(input int unsigned n);
    cyc4 = n[3:0];
  endfunction

  assign start_rd = sw_wr && (sw_addr == asram_pkg::REG_CMD)
                    && sw_wdata[asram_pkg::CMD_RD_BIT] && !busy_q;
  assign start_wr = sw_wr && (sw_addr == asram_pkg::REG_CMD)
                    && sw_wdata[asram_pkg::CMD_WR_BIT]
                    && !sw_wdata[asram_pkg::CMD_RD_BIT] && !busy_q;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (sw_wr && !busy_q) begin
      if (sw_addr == asram_pkg::REG_ADDR) begin
        addr_q <= sw_wdata[16:0];
      end
      if (sw_addr == asram_pkg::REG_WDATA) begin
        wdata_q <= sw_wdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_rdata <= asram_pkg::RESET_WORD;
    end else if (sw_rd) begin
      case (sw_addr)
        asram_pkg::REG_ADDR:   sw_rdata <= {15'h0000, addr_q};
        asram_pkg::REG_WDATA:  sw_rdata <= {24'h000000, wdata_q};
        asram_pkg::REG_STATUS: sw_rdata <= {22'h000000, done_q, busy_q, rdata_q};
        default:               sw_rdata <= asram_pkg::RESET_WORD;
      endcase
    end else begin
      sw_rdata <= asram_pkg::RESET_WORD;
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= asram_pkg::ASRAM_IDLE;
      cnt_q   <= asram_pkg::CNT_ZERO;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      case (state_q)
        asram_pkg::ASRAM_IDLE: begin
          if (start_rd) begin
            state_q <= asram_pkg::ASRAM_READ;
            // two extra cycles cover the input synchroniser
            cnt_q   <= cyc4(asram_pkg::RD_CYC + 2);
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
          end else if (start_wr) begin
            state_q <= asram_pkg::ASRAM_WRITE;
            cnt_q   <= cyc4(asram_pkg::WC_CYC);
            busy_q  <= 1'b1;
            done_q  <= 1'b0;
          end
        end
        asram_pkg::ASRAM_READ: begin
          if (cnt_q == asram_pkg::CNT_ZERO) begin
            rdata_q <= din_sync;
            state_q <= asram_pkg::ASRAM_TURN;
            cnt_q   <= cyc4(asram_pkg::HZ_CYC);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        asram_pkg::ASRAM_WRITE: begin
          if (cnt_q == asram_pkg::CNT_ZERO) begin
            state_q <= asram_pkg::ASRAM_TURN;
            cnt_q   <= cyc4(asram_pkg::HZ_CYC);
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        asram_pkg::ASRAM_TURN: begin
          // bus turnaround lets the memory release the data lines
          if (cnt_q == asram_pkg::CNT_ZERO) begin
            state_q <= asram_pkg::ASRAM_IDLE;
            busy_q  <= 1'b0;
            done_q  <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= asram_pkg::ASRAM_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q                  <= 1'b0;
      write_strobe_n         <= 1'b1;
      output_enable_n        <= 1'b1;
      shared_data_lines_oe_n <= 1'b1;
      shared_data_lines_out  <= '0;
      word_address_lines     <= '0;
    end else begin
      // address set a cycle before select and held through the access
      if (state_q == asram_pkg::ASRAM_IDLE) begin
        word_address_lines <= addr_q;
      end
      sel_q <= (state_q == asram_pkg::ASRAM_READ) ||
               (state_q == asram_pkg::ASRAM_WRITE);
      // strobe low only strictly inside select, over WP cycles
      write_strobe_n <= !((state_q == asram_pkg::ASRAM_WRITE) &&
                          (cnt_q <= cyc4(asram_pkg::WP_CYC)) &&
                          (cnt_q != asram_pkg::CNT_ZERO));
      output_enable_n <= !(state_q == asram_pkg::ASRAM_READ);
      shared_data_lines_oe_n <= !(state_q == asram_pkg::ASRAM_WRITE);
      shared_data_lines_out  <= wdata_q;
    end
  end

  assign select_low_active_n = !sel_q;
  assign select_high_active  = sel_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // strobe stays low for exactly one write-pulse cycle, then releases
  sequence s_write_pulse;
    !write_strobe_n ##1 write_strobe_n;
  endsequence

  a_read_strobe_high: assert property (@(posedge clk) disable iff (rst)
    !output_enable_n |-> write_strobe_n)
    else $error("write strobe low during read");
  a_strobe_in_select: assert property (@(posedge clk) disable iff (rst)
    !write_strobe_n |-> (!select_low_active_n && select_high_active))
    else $error("write strobe outside select");
  a_select_polarity: assert property (@(posedge clk) disable iff (rst)
    select_low_active_n != select_high_active)
    else $error("selects not complementary");
  a_addr_stable_sel: assert property (@(posedge clk) disable iff (rst)
    (select_high_active && $past(select_high_active)) |->
      $stable(word_address_lines))
    else $error("address moved during access");
  a_write_data_drv: assert property (@(posedge clk) disable iff (rst)
    !write_strobe_n |-> !shared_data_lines_oe_n)
    else $error("data not driven during write");
  a_no_drive_clash: assert property (@(posedge clk) disable iff (rst)
    !(!shared_data_lines_oe_n && !output_enable_n))
    else $error("host and memory drive together");
  a_write_pulse_len: assert property (@(posedge clk) disable iff (rst)
    $fell(write_strobe_n) |-> s_write_pulse)
    else $error("write pulse length wrong");
  a_idle_deselect: assert property (@(posedge clk) disable iff (rst)
    !busy_q |-> ##1 select_low_active_n)
    else $error("selected while idle");
endmodule // asram_host
`default_nettype wire

// *** asram_mem_model.sv ***
// asram_mem_model: behavioural 128K x 8 asynchronous memory.
// assumes its pins come straight from asram_host; no clock, no reset.
`timescale 1ns/100ps
`default_nettype none
module asram_mem_model #(
  parameter int unsigned ACC_NS = 0
) (
  input  wire logic [16:0] word_address_lines,
  input  wire logic        select_low_active_n,
  input  wire logic        select_high_active,
  input  wire logic        write_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic [7:0]  host_d,
  input  wire logic        host_oe_n,
  output logic      [7:0]  shared_data_lines
);
  logic [7:0] mem [0:131071];
  logic [7:0] last;
  logic [7:0] mem_q;
  wire logic  sel = !select_low_active_n && select_high_active;
  wire logic  drv = sel && write_strobe_n && !output_enable_n;
  always @* if (sel && !write_strobe_n) mem[word_address_lines] = shared_data_lines;
  // released lines show the inverse of the last driven value
  always @* if (!host_oe_n) last = host_d; else if (drv) last = mem[word_address_lines];
  assign #(ACC_NS) mem_q = drv ? mem[word_address_lines] : ~last;
  assign shared_data_lines = !host_oe_n ? host_d : mem_q;
endmodule // asram_mem_model
`default_nettype wire

// *** test_asram_host.sv ***
// test_asram_host: self-checking bench for asram_host with a memory model.
// assumes the register map of asram_pkg and the status layout of asram_host.
`timescale 1ns/100ps
`default_nettype none
module test_asram_host;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata, m;
  logic [16:0] word_address_lines, addr_d, a [8];
  logic        select_low_active_n, select_high_active, write_strobe_n, output_enable_n;
  logic [7:0]  dq_in, dq_out, d [8];
  logic        dq_oe_n, rd_d1 = 1'b0, sel_d = 1'b0;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [31:0] exp_q [$], msk_q [$];
  always #12.5 clk = ~clk;
  asram_host u_asram_host (.clk(clk), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .word_address_lines(word_address_lines),
    .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .shared_data_lines_in(dq_in), .shared_data_lines_out(dq_out), .shared_data_lines_oe_n(dq_oe_n));
  asram_mem_model #(.ACC_NS(40)) u_asram_mem_model (.word_address_lines(word_address_lines),
    .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n), .host_d(dq_out),
    .host_oe_n(dq_oe_n), .shared_data_lines(dq_in));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("counts: %0d compares, %0d errors", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] dt);
    @(posedge clk);
    sw_addr <= ad; sw_wdata <= dt; sw_wr <= 1'b1; sw_rd <= 1'b0;
  endtask
  task rd(input logic [3:0] ad, input logic [31:0] e, input logic [31:0] mk);
    @(posedge clk);
    sw_addr <= ad; sw_rd <= 1'b1; sw_wr <= 1'b0;
    exp_q.push_back(e);
    msk_q.push_back(mk);
  endtask
  task idle;
    @(posedge clk);
    sw_wr <= 1'b0; sw_rd <= 1'b0;
  endtask
  task acc(input logic [16:0] ad, input logic [7:0] dt, input logic w);
    wr(asram_pkg::REG_ADDR, {15'h0, ad});
    wr(asram_pkg::REG_WDATA, {24'h0, dt});
    wr(asram_pkg::REG_CMD, w ? 32'h2 : 32'h1);
    idle;
    for (int n = 0; n < 40; n++) begin
      rd(asram_pkg::REG_STATUS, 32'h0, 32'h0);
      idle;
      @(negedge clk);
      if (sw_rdata[8] === 1'b0) break;
    end
    rd(asram_pkg::REG_STATUS, {22'h0, 2'b10, dt}, w ? 32'h300 : 32'h3FF);
    idle;
    if (w) chk(u_asram_mem_model.mem[ad], dt);
  endtask
  // pin watcher and read-data checker
  always @(posedge clk) begin
    if (rd_d1) begin m = msk_q.pop_front(); chk(sw_rdata & m, exp_q.pop_front() & m); end
    if (!rst) begin
      chk(select_high_active, !select_low_active_n);
      if (!select_low_active_n && !output_enable_n) chk(write_strobe_n, 1'b1);
      if (!dq_oe_n) chk(output_enable_n, 1'b1);
      if (!select_low_active_n && sel_d) chk(word_address_lines, addr_d);
    end
    rd_d1 <= sw_rd;
    sel_d <= !select_low_active_n;
    addr_d <= word_address_lines;
  end
  initial begin
    #2000000;
    error_cnt++;
    finish_test;
  end
  initial begin
    void'($urandom(35699));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({select_low_active_n, select_high_active, write_strobe_n, output_enable_n}, 4'hB);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a[i] = {14'($urandom), 3'(i)};
      d[i] = 8'($urandom);
    end
    a[0] = 17'h00000;
    a[7] = 17'h1FFFF;
    for (int i = 0; i < 8; i++) acc(a[i], d[i], 1'b1);
    for (int i = 7; i >= 0; i--) acc(a[i], d[i], 1'b0);
    $display("test write_read done");
    rd(4'h2, 32'h0, 32'hFFFFFFFF);
    rd(4'h6, 32'h0, 32'hFFFFFFFF);
    idle;
    repeat (3) @(posedge clk);
    $display("test unmapped done");
    finish_test;
  end
endmodule // test_asram_host
`default_nettype wire
